/* rtl/rtc_counter.sv */
// Purpose: real-time counter with wrap, compare and periodic timer over AHB-Lite
// Assumes: counter clock sources arrive as pins far slower than hclk
// Notes: reads insert one wait state so read data comes from flip-flops
// Behaviour
// R01: a two-bit field picks the counter clock from internal 32k, internal 1k, crystal or external pin.
// R02: the counter is 16 bits, reset to zero, low byte at the base index and high byte just above.
// R03: a counter or period write takes effect two counter clock ticks after the write.
// R04: software waits for the counter busy flag to clear before writing the counter.
// R05: software waits for the period busy flag to clear before writing the period.
// R06: the period is 16 bits, reset to all ones, low byte at the base index and high byte above.
// R07: the compare value is 16 bits, reset to zero, low byte at the base index and high byte above.
// R08: a four-bit interval gives no event at zero, 4 to 32768 ticks for 1 to 14, and 15 is unused.
// R09: the timer enable bit at position zero starts the periodic timer at one and stops it at zero.
// R10: a read-only busy bit stays high while a timer control write crosses to the counter clock.
// R11: the periodic interrupt enable bit passes the periodic request at one and masks it at zero.
// R12: on reaching the period the counter wraps to zero and sets the wrap flag, cleared by a one.
// R13: when the counter equals the compare value the match flag is set, cleared by a one.
// R14: each elapsed timer interval sets the periodic flag, cleared by writing a one.
// R15: no periodic event unless the timer is on and the interval is nonzero and not reserved.
// R16: software waits for the timer control busy bit to clear before writing the control again.
//
// Register access over AHB-Lite was chosen for this implementation.
module rtc_counter
  import rtc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic internal_32k_oscillator,
  input wire logic internal_1k_source,
  input wire logic crystal_input_pin,
  input wire logic external_clock_source,
  output logic irq
);

  // ---------------- bus slave ----------------
  bus_addr_t dph_q;
  logic rd_wait_q;
  logic [31:0] hrdata_q;
  logic [7:0] rd_byte;

  wire addr_take = hsel && htrans[1] && hready;
  wire wr_act = dph_q.valid && dph_q.write;
  wire [7:0] wdat = hwdata[7:0];
  wire [7:0] widx = dph_q.idx;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_q <= '0;
      rd_wait_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      if (hready) begin
        dph_q <= '{idx: haddr[9:2], write: hwrite, valid: addr_take};
      end
      rd_wait_q <= addr_take && !hwrite;
      if (rd_wait_q) begin
        hrdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  // only whole words exist, so hsize is accepted without checking
  wire unused_size = ^hsize;
  assign hreadyout = !rd_wait_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  wire wr_src = wr_act && widx == CLK_SRC_IDX;
  wire wr_cnt_lo = wr_act && widx == COUNT_LO_IDX;
  wire wr_cnt_hi = wr_act && widx == COUNT_HI_IDX;
  wire wr_per_lo = wr_act && widx == PERIOD_LO_IDX;
  wire wr_per_hi = wr_act && widx == PERIOD_HI_IDX;
  wire wr_mat_lo = wr_act && widx == MATCH_LO_IDX;
  wire wr_mat_hi = wr_act && widx == MATCH_HI_IDX;
  wire wr_pit = wr_act && widx == PIT_CTRL_IDX;
  wire wr_pien = wr_act && widx == PIT_IRQ_EN_IDX;
  wire wr_flags = wr_act && widx == IRQ_FLAGS_IDX;
  wire wr_mask = wr_act && widx == IRQ_MASK_IDX;
  wire wr_cnt = wr_cnt_lo || wr_cnt_hi;
  wire wr_per = wr_per_lo || wr_per_hi;

  // ---------------- clock source and tick ----------------
  clk_src_t src_q;
  logic [3:0] src_rise;
  wire [3:0] src_pins = {external_clock_source, crystal_input_pin,
                         internal_1k_source, internal_32k_oscillator};

  for (genvar g = 0; g < 4; g++) begin : g_pin
    pin_edge_sync u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin(src_pins[g]),
      .rise(src_rise[g])
    );
  end

  // every pin is synchronised, so switching source cannot make a runt tick
  wire tick = src_rise[src_q]; // R01

  // ---------------- registers ----------------
  logic [15:0] cnt_q, cnt_sw_q, per_q, per_sw_q, match_q;
  pit_ctrl_t pit_sw_q, pit_q;
  sync_state_t cnt_sync_q, per_sync_q, pit_sync_q;
  logic pien_q;
  logic [2:0] flags_q, mask_q;
  logic pit_evt;

  wire cnt_apply = tick && cnt_sync_q == SYNC_WAIT1; // R03
  wire per_apply = tick && per_sync_q == SYNC_WAIT1; // R03
  wire pit_apply = tick && pit_sync_q == SYNC_WAIT1;
  wire cnt_busy = cnt_sync_q != SYNC_IDLE;
  wire per_busy = per_sync_q != SYNC_IDLE;
  wire pit_busy = pit_sync_q != SYNC_IDLE; // R10

  wire wrap_evt = tick && !cnt_apply && cnt_q == per_q; // R12
  wire match_evt = tick && cnt_q == match_q; // R13
  wire [2:0] set_evt = {pit_evt, match_evt, wrap_evt}; // R14
  wire [2:0] clr = wr_flags ? wdat[2:0] : 3'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_q <= SRC_INTERNAL_32K;
      cnt_sw_q <= COUNT_RST;
      per_sw_q <= PERIOD_RST;
      match_q <= MATCH_RST;
      pit_sw_q <= '0;
      pien_q <= 1'b0;
      mask_q <= 3'h0;
    end else begin
      if (wr_src) src_q <= clk_src_t'(wdat[1:0]); // R01
      if (wr_cnt_lo) cnt_sw_q[7:0] <= wdat; // R02
      if (wr_cnt_hi) cnt_sw_q[15:8] <= wdat; // R02
      if (wr_per_lo) per_sw_q[7:0] <= wdat; // R06
      if (wr_per_hi) per_sw_q[15:8] <= wdat; // R06
      if (wr_mat_lo) match_q[7:0] <= wdat; // R07
      if (wr_mat_hi) match_q[15:8] <= wdat; // R07
      if (wr_pit) pit_sw_q <= '{interval: wdat[6:3], en: wdat[PIT_EN_BIT]}; // R08 R09
      if (wr_pien) pien_q <= wdat[0]; // R11
      if (wr_mask) mask_q <= wdat[2:0];
    end
  end

  // writes during busy are still taken; software is expected to wait
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_sync_q <= SYNC_IDLE;
      per_sync_q <= SYNC_IDLE;
      pit_sync_q <= SYNC_IDLE;
    end else begin
      cnt_sync_q <= sync_next(cnt_sync_q, wr_cnt, tick); // R03 R04
      per_sync_q <= sync_next(per_sync_q, wr_per, tick); // R03 R05
      pit_sync_q <= sync_next(pit_sync_q, wr_pit, tick); // R10 R16
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= COUNT_RST;
      per_q <= PERIOD_RST;
      pit_q <= '0;
    end else begin
      if (cnt_apply) begin
        cnt_q <= cnt_sw_q; // R03
      end else if (wrap_evt) begin
        cnt_q <= COUNT_RST; // R12
      end else if (tick) begin
        cnt_q <= cnt_q + 16'h0001;
      end
      if (per_apply) per_q <= per_sw_q; // R03
      if (pit_apply) pit_q <= pit_sw_q; // R09
    end
  end

  // set beats clear in the same cycle so no event is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= 3'h0;
    end else begin
      flags_q <= (flags_q & ~clr) | set_evt; // R12 R13 R14
    end
  end

  pit_timer #(
    .PRESCALE_W(15)
  ) u_pit (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick),
    .ctrl(pit_q),
    .evt(pit_evt)
  );

  wire [2:0] gate = {pien_q, 2'b11}; // R11
  assign irq = |(flags_q & mask_q & gate);

  // ---------------- read mux ----------------
  function automatic logic [7:0] rd_mux(logic [7:0] idx);
    logic [7:0] r;
    r = 8'h00;
    case (idx)
      CLK_SRC_IDX: r = {6'h00, src_q};
      COUNT_LO_IDX: r = cnt_q[7:0];
      COUNT_HI_IDX: r = cnt_q[15:8];
      PERIOD_LO_IDX: r = per_sw_q[7:0];
      PERIOD_HI_IDX: r = per_sw_q[15:8];
      MATCH_LO_IDX: r = match_q[7:0];
      MATCH_HI_IDX: r = match_q[15:8];
      PIT_CTRL_IDX: r = {1'b0, pit_sw_q.interval, 2'b00, pit_sw_q.en};
      PIT_SYNC_IDX: r = {7'h00, pit_busy}; // R10
      PIT_IRQ_EN_IDX: r = {7'h00, pien_q};
      IRQ_FLAGS_IDX: r = {5'h00, flags_q};
      IRQ_MASK_IDX: r = {5'h00, mask_q};
      SYNC_BUSY_IDX: r = {5'h00, per_busy, cnt_busy, unused_size & 1'b0};
      default: r = 8'h00;
    endcase
    return r;
  endfunction : rd_mux

  assign rd_byte = rd_mux(dph_q.idx);

  // ---------------- checks ----------------
  src_pick_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (src_q == SRC_INTERNAL_1K && !src_rise[1]) |-> !tick)
    else $error("tick from unselected source"); // R01
  count_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> cnt_q == 16'h0000 && per_q == 16'hffff)
    else $error("counter or period reset value wrong"); // R02
  two_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_cnt && !tick) |=> cnt_busy && cnt_sync_q == SYNC_WAIT2)
    else $error("count write did not start two-tick transfer"); // R03
  count_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cnt_apply |=> cnt_q == $past(cnt_sw_q))
    else $error("count write not applied"); // R03
  period_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
    per_apply |=> per_q == $past(per_sw_q) && !per_busy || $past(wr_per))
    else $error("period write not applied"); // R06
  match_rst_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> match_q == 16'h0000)
    else $error("compare reset value wrong"); // R07
  pit_busy_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pit |=> pit_busy ##0 rd_mux(PIT_SYNC_IDX) == 8'h01)
    else $error("control busy bit not raised"); // R10
  pi_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (flags_q == 3'h4 && !pien_q) |-> !irq)
    else $error("periodic request passed while disabled"); // R11
  wrap_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wrap_evt |=> cnt_q == 16'h0000 && flags_q[WRAP_BIT])
    else $error("wrap did not zero counter and set flag"); // R12
  match_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    match_evt |=> flags_q[MATCH_BIT]) else $error("match flag not set"); // R13
  periodic_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pit_evt |=> flags_q[PERIODIC_BIT]) else $error("periodic flag not set"); // R14


  // bus side: one wait state per read, never an error
  read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_take && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state not exactly one cycle");
  okay_resp_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hresp == 1'b0)
    else $error("error response driven");
  rdata_upper_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hrdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  // register writes land one cycle after the data phase
  src_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_src |=> src_q == $past(wdat[1:0]))
    else $error("clock source write lost"); // R01
  match_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_mat_lo |=> match_q[7:0] == $past(wdat))
    else $error("compare low byte write lost"); // R07
  pien_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pien |=> pien_q == $past(wdat[0]))
    else $error("periodic enable write lost"); // R11
  mask_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_mask |=> mask_q == $past(wdat[2:0]))
    else $error("mask write lost");

  // sync handshakes only move on a write or a tick
  per_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_per |=> per_busy && per_sync_q == SYNC_WAIT2)
    else $error("period write did not start two-tick transfer"); // R03
  cnt_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (cnt_sync_q == SYNC_IDLE && !wr_cnt) |=> cnt_sync_q == SYNC_IDLE)
    else $error("count busy raised without a write"); // R03
  per_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (per_sync_q == SYNC_IDLE && !wr_per) |=> per_sync_q == SYNC_IDLE)
    else $error("period busy raised without a write"); // R03
  pit_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (pit_busy && !wr_pit && !tick) |=> pit_busy)
    else $error("control busy dropped without a tick"); // R10
  pit_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pit_apply |=> pit_q == $past(pit_sw_q))
    else $error("timer control not applied"); // R09
  per_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !per_apply |=> $stable(per_q))
    else $error("period changed outside the transfer"); // R03

  // counter moves only on a tick, by one unless loaded or wrapped
  count_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !tick |=> cnt_q == $past(cnt_q))
    else $error("counter moved without a tick"); // R03
  count_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && !cnt_apply && !wrap_evt) |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("counter did not step by one"); // R02

  // flags only grow unless software writes ones
  flag_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_flags |=> (flags_q & $past(flags_q)) == $past(flags_q))
    else $error("flag dropped without a clear"); // R12
  wrap_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_flags && wdat[WRAP_BIT] && !wrap_evt) |=> !flags_q[WRAP_BIT])
    else $error("wrap flag not cleared"); // R12
  match_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_flags && wdat[MATCH_BIT] && !match_evt) |=> !flags_q[MATCH_BIT])
    else $error("match flag not cleared"); // R13
  periodic_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_flags && wdat[PERIODIC_BIT] && !pit_evt) |=> !flags_q[PERIODIC_BIT])
    else $error("periodic flag not cleared"); // R14
  irq_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
    irq |-> (flags_q & mask_q) != 3'h0)
    else $error("interrupt without an unmasked flag"); // R11

  wrap_seen_c: cover property (@(posedge hclk) disable iff (!hresetn) wrap_evt);
  count_load_c: cover property (@(posedge hclk) disable iff (!hresetn) cnt_apply);
  pit_restart_c: cover property (@(posedge hclk) disable iff (!hresetn) wr_pit && pit_busy);
  match_seen_c: cover property (@(posedge hclk) disable iff (!hresetn) match_evt);
  periodic_seen_c: cover property (@(posedge hclk) disable iff (!hresetn) pit_evt && irq);

endmodule : rtc_counter

/* rtl/rtc_pkg.sv */
// Purpose: shared constants, types and helpers for the real-time counter block
// Assumes: register index times four gives the byte address on the bus
// Notes: sync busy, flag and mask registers sit above the periodic timer block
package rtc_pkg;

  // register indices, byte address is index * 4
  localparam logic [7:0] CLK_SRC_IDX = 8'h07;
  localparam logic [7:0] COUNT_LO_IDX = 8'h08;
  localparam logic [7:0] COUNT_HI_IDX = 8'h09;
  localparam logic [7:0] PERIOD_LO_IDX = 8'h0a;
  localparam logic [7:0] PERIOD_HI_IDX = 8'h0b;
  localparam logic [7:0] MATCH_LO_IDX = 8'h0c;
  localparam logic [7:0] MATCH_HI_IDX = 8'h0d;
  localparam logic [7:0] PIT_CTRL_IDX = 8'h10;
  localparam logic [7:0] PIT_SYNC_IDX = 8'h11;
  localparam logic [7:0] PIT_IRQ_EN_IDX = 8'h12;
  localparam logic [7:0] IRQ_FLAGS_IDX = 8'h20;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h21;
  localparam logic [7:0] SYNC_BUSY_IDX = 8'h22;

  // values after reset
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'hffff;
  localparam logic [15:0] MATCH_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // field positions
  localparam int PIT_EN_BIT = 0;
  localparam int PIT_INTERVAL_LSB = 3;
  localparam int WRAP_BIT = 0;
  localparam int MATCH_BIT = 1;
  localparam int PERIODIC_BIT = 2;
  localparam int COUNT_BUSY_BIT = 1;
  localparam int PERIOD_BUSY_BIT = 2;
  localparam logic [3:0] INTERVAL_OFF = 4'h0;
  localparam logic [3:0] INTERVAL_RSVD = 4'hf;

  typedef enum logic [1:0] {
    SRC_INTERNAL_32K = 2'b00,
    SRC_INTERNAL_1K = 2'b01,
    SRC_CRYSTAL = 2'b10,
    SRC_EXTERNAL = 2'b11
  } clk_src_t;

  typedef enum logic [1:0] {
    SYNC_IDLE = 2'b00,
    SYNC_WAIT1 = 2'b01,
    SYNC_WAIT2 = 2'b10
  } sync_state_t;

  typedef struct packed {
    logic [7:0] idx;
    logic write;
    logic valid;
  } bus_addr_t;

  typedef struct packed {
    logic [3:0] interval;
    logic en;
  } pit_ctrl_t;

  // write restarts the two-tick transfer, each counter tick advances it
  function automatic sync_state_t sync_next(sync_state_t s, logic wr, logic tick);
    sync_state_t n;
    n = s;
    if (wr) begin
      n = SYNC_WAIT2;
    end else if (tick) begin
      case (s)
        SYNC_WAIT2: n = SYNC_WAIT1;
        SYNC_WAIT1: n = SYNC_IDLE;
        SYNC_IDLE: n = SYNC_IDLE;
        default: n = SYNC_IDLE;
      endcase
    end
    return n;
  endfunction : sync_next

endpackage : rtc_pkg

/* rtl/pin_edge_sync.sv */
// Purpose: bring one slow clock pin into hclk and mark its rising edges
// Assumes: pin toggles much slower than hclk
// Notes: a change counts only once the second and third stages agree
module pin_edge_sync
  import rtc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin,
  output logic rise
);
  logic s1_q, s2_q, s3_q, lvl_q;
  wire agree = (s2_q == s3_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree) begin
        lvl_q <= s3_q;
      end
    end
  end

  assign rise = agree && s3_q && !lvl_q;

  edge_once_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rise |=> !rise) else $error("edge pulse longer than one cycle");

endmodule : pin_edge_sync

/* rtl/pit_timer.sv */
// Purpose: periodic event from the counter tick, spacing a power of two
// Assumes: tick is a one-cycle pulse per counter clock
// Notes: prescaler is cleared while stopped, so a restart gives a full interval
module pit_timer
  import rtc_pkg::*;
#(
  parameter int PRESCALE_W = 15
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  input wire pit_ctrl_t ctrl,
  output logic evt
);
  logic [PRESCALE_W-1:0] pre_q;
  logic evt_q;
  logic [15:0] full;
  wire running = ctrl.en && ctrl.interval != INTERVAL_OFF && ctrl.interval != INTERVAL_RSVD;
  assign full = (16'h0001 << (ctrl.interval + 4'h1)) - 16'h0001; // R08
  wire [PRESCALE_W-1:0] mask = full[PRESCALE_W-1:0];
  wire hit = tick && running && ((pre_q & mask) == mask); // R08 R15

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q <= '0;
      evt_q <= 1'b0;
    end else begin
      evt_q <= hit;
      if (!running) begin
        pre_q <= '0; // R09
      end else if (tick) begin
        pre_q <= pre_q + 1'b1;
      end
    end
  end

  assign evt = evt_q;

  evt_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
    evt |-> $past(running) && $past(tick)) else $error("periodic event without cause"); // R15
  stop_clears_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl.en |=> pre_q == '0) else $error("prescaler runs while stopped"); // R09
  short_interval_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && running && ctrl.interval == 4'h1 && pre_q[1:0] == 2'h3) |=> evt)
    else $error("interval one event missing on the fourth tick"); // R08

endmodule : pit_timer

/* dv/rtc_counter_test.sv */
// Purpose: self-checking bench for the real-time counter over AHB-Lite
// Assumes: each counter tick is a slow pin pulse of 4 hclk high and 4 low
// Notes: only intervals 1 and 3 are run, longer ones up to 32768 ticks would make the run too long
module rtc_counter_test
  import rtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] pins;
  int n_errors = 0;
  int checks_done = 0;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  rtc_counter dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .internal_32k_oscillator(pins[0]),
    .internal_1k_source(pins[1]), .crystal_input_pin(pins[2]),
    .external_clock_source(pins[3]), .irq(irq)
  );

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // values read right after an edge are still the ones sampled at that edge
  task automatic bus(input logic [7:0] idx, input logic w, input logic [31:0] wd,
                     output logic [31:0] rdat);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {22'h000000, idx, 2'b00};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] junk;
    bus(idx, 1'b1, d, junk);
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [31:0] d);
    bus(idx, 1'b0, 32'h0, d);
  endtask : rd

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input string what);
    logic [31:0] v;
    rd(idx, v);
    chk(what, exp, v);
  endtask : rdchk

  // let the register update of the last write land before looking at irq
  task automatic irqchk(input logic exp);
    @(posedge hclk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask : irqchk

  task automatic pulse(input int s, input int n);
    repeat (n) begin
      pins[s] <= 1'b1;
      repeat (4) @(posedge hclk);
      pins[s] <= 1'b0;
      repeat (4) @(posedge hclk);
    end
  endtask : pulse

  task automatic t_reset();
    rdchk(CLK_SRC_IDX, 32'h0, "clk_src");
    rdchk(COUNT_LO_IDX, {24'h0, COUNT_RST[7:0]}, "count_lo");
    rdchk(COUNT_HI_IDX, {24'h0, COUNT_RST[15:8]}, "count_hi");
    rdchk(PERIOD_LO_IDX, {24'h0, PERIOD_RST[7:0]}, "period_lo");
    rdchk(PERIOD_HI_IDX, {24'h0, PERIOD_RST[15:8]}, "period_hi");
    rdchk(MATCH_LO_IDX, {24'h0, MATCH_RST[7:0]}, "match_lo");
    rdchk(MATCH_HI_IDX, {24'h0, MATCH_RST[15:8]}, "match_hi");
    rdchk(PIT_CTRL_IDX, 32'h0, "pit_ctrl");
    rdchk(PIT_SYNC_IDX, 32'h0, "pit_sync");
    rdchk(PIT_IRQ_EN_IDX, 32'h0, "pien");
    rdchk(IRQ_MASK_IDX, 32'h0, "mask");
    rdchk(8'h3f, 32'h0, "unmapped");
    irqchk(1'b0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs();
    wr(MATCH_LO_IDX, 32'hffffff3c);
    wr(MATCH_HI_IDX, 32'h0000005a);
    rdchk(MATCH_LO_IDX, 32'h3c, "match_lo");
    rdchk(MATCH_HI_IDX, 32'h5a, "match_hi");
    wr(PIT_IRQ_EN_IDX, 32'h1);
    rdchk(PIT_IRQ_EN_IDX, 32'h1, "pien");
    wr(PIT_IRQ_EN_IDX, 32'h0);
    wr(CLK_SRC_IDX, 32'h3);
    rdchk(CLK_SRC_IDX, 32'h3, "clk_src");
    wr(8'h3f, 32'hff);
    rdchk(8'h3f, 32'h0, "unmapped");
    $display("test regs done");
  endtask : t_regs

  task automatic t_src();
    logic [31:0] a, b;
    for (int s = 0; s < 4; s++) begin
      wr(CLK_SRC_IDX, s);
      rd(COUNT_LO_IDX, a);
      pulse(s, 3);
      pulse((s + 1) % 4, 2);
      rd(COUNT_LO_IDX, b);
      chk("ticks of source", 32'h3, (b - a) & 32'hff);
    end
    wr(CLK_SRC_IDX, 32'h0);
    wr(COUNT_HI_IDX, 32'h0);
    wr(COUNT_LO_IDX, 32'h40);
    rdchk(SYNC_BUSY_IDX, 32'h2, "count busy");
    pulse(0, 1);
    rdchk(SYNC_BUSY_IDX, 32'h2, "count busy");
    pulse(0, 1);
    rdchk(SYNC_BUSY_IDX, 32'h0, "count busy");
    rdchk(COUNT_LO_IDX, 32'h40, "count_lo");
    pulse(0, 3);
    rdchk(COUNT_LO_IDX, 32'h43, "count_lo");
    wr(PERIOD_LO_IDX, 32'hff);
    rdchk(SYNC_BUSY_IDX, 32'h4, "period busy");
    pulse(0, 2);
    rdchk(SYNC_BUSY_IDX, 32'h0, "period busy");
    $display("test src done");
  endtask : t_src

  task automatic t_wrap();
    wr(MATCH_LO_IDX, 32'h3);
    wr(MATCH_HI_IDX, 32'h0);
    wr(PERIOD_LO_IDX, 32'h5);
    wr(PERIOD_HI_IDX, 32'h0);
    wr(COUNT_LO_IDX, 32'h0);
    wr(COUNT_HI_IDX, 32'h0);
    pulse(0, 2);
    wr(IRQ_FLAGS_IDX, 32'h7);
    wr(IRQ_MASK_IDX, 32'h3);
    rdchk(IRQ_FLAGS_IDX, 32'h0, "flags");
    pulse(0, 4);
    rdchk(COUNT_LO_IDX, 32'h4, "count_lo");
    rdchk(IRQ_FLAGS_IDX, 32'h2, "flags");
    irqchk(1'b1);
    wr(IRQ_FLAGS_IDX, 32'h2);
    rdchk(IRQ_FLAGS_IDX, 32'h0, "flags");
    irqchk(1'b0);
    pulse(0, 2);
    rdchk(COUNT_LO_IDX, 32'h0, "count_lo");
    rdchk(IRQ_FLAGS_IDX, 32'h1, "flags");
    wr(IRQ_MASK_IDX, 32'h0);
    irqchk(1'b0);
    wr(IRQ_MASK_IDX, 32'h1);
    irqchk(1'b1);
    wr(IRQ_FLAGS_IDX, 32'h1);
    irqchk(1'b0);
    wr(PERIOD_LO_IDX, 32'hff);
    wr(PERIOD_HI_IDX, 32'hff);
    pulse(0, 2);
    $display("test wrap done");
  endtask : t_wrap

  // ticks from a cleared periodic flag until it is seen set again
  task automatic gap(output int n);
    logic [31:0] v;
    wr(IRQ_FLAGS_IDX, 32'h4);
    n = 0;
    v = 32'h0;
    while (v[PERIODIC_BIT] !== 1'b1 && n < 40) begin
      pulse(0, 1);
      n++;
      rd(IRQ_FLAGS_IDX, v);
    end
  endtask : gap

  task automatic t_pit();
    int n;
    logic [7:0] off_ctrl [3] = '{8'h01, 8'h79, 8'h08};
    wr(IRQ_MASK_IDX, 32'h4);
    wr(PIT_IRQ_EN_IDX, 32'h1);
    for (int iv = 1; iv < 4; iv += 2) begin
      wr(PIT_CTRL_IDX, (iv << 3) | 1);
      rdchk(PIT_SYNC_IDX, 32'h1, "pit busy");
      pulse(0, 2);
      rdchk(PIT_SYNC_IDX, 32'h0, "pit busy");
      gap(n);
      gap(n);
      chk("pit spacing", 1 << (iv + 1), n);
    end
    irqchk(1'b1);
    wr(PIT_IRQ_EN_IDX, 32'h0);
    irqchk(1'b0);
    foreach (off_ctrl[i]) begin
      wr(PIT_CTRL_IDX, {24'h0, off_ctrl[i]});
      pulse(0, 2);
      // the match flag from the earlier count pass is sticky, so clear all three
      wr(IRQ_FLAGS_IDX, 32'h7);
      pulse(0, 10);
      rdchk(IRQ_FLAGS_IDX, 32'h0, "no periodic event");
    end
    $display("test pit done");
  endtask : t_pit

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pins = 4'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_regs();
    t_src();
    t_wrap();
    t_pit();
    test_done();
  end

  // the whole run needs under two thousand cycles, this leaves a wide margin
  initial begin
    repeat (40000) @(posedge hclk);
    n_errors++;
    $display("watchdog ran out");
    test_done();
  end

endmodule : rtc_counter_test
